// file: pkg/rate_sel_pkg.sv
// Constants and types for the output clock rate selector
package rate_sel_pkg;
    // Register offsets
    localparam logic [7:0] ETH_SELECT_OFFSET   = 8'h20;
    localparam logic [7:0] AUX_FAMILY_OFFSET   = 8'h38;
    localparam logic [7:0] AUX_CODE_OFFSET     = 8'h39;
    localparam logic [7:0] RATE_P12_OFFSET     = 8'h60;
    localparam logic [7:0] RATE_P34_OFFSET     = 8'h61;
    localparam logic [7:0] RATE_P56_OFFSET     = 8'h62;
    localparam logic [7:0] RATE_P7_OFFSET      = 8'h63;
    localparam logic [7:0] MISC_CTRL_OFFSET    = 8'h70;
    // Field positions
    localparam int AUX_A_FAMILY_BIT  = 5;
    localparam int AUX_B_FAMILY_BIT  = 6;
    localparam int AUX_A_CODE_LSB    = 4;
    localparam int AUX_B_CODE_LSB    = 6;
    localparam int COMPOSITE_EN_BIT  = 0;
    localparam int SEC_FB_APLL_BIT   = 1;
    localparam int ETH_PORTS         = 6;
    localparam int NUM_PORTS         = 7;
    // Reset values
    localparam logic [7:0] REG_RESET = 8'h00;
    // Main output synthesizer rate feeding the auxiliary synthesizer
    localparam int AUX_SYNTH_REF_KHZ = 77760;
    // Source of each output port
    typedef enum logic [3:0] {
        SRC_OFF, SRC_2K, SRC_8K, SRC_AUX_A, SRC_AUX_B, SRC_MAIN_APLL,
        SRC_SEC_APLL, SRC_ETH_25M, SRC_ETH_50M, SRC_ETH_62M5, SRC_ETH_125M
    } src_t;
    // Rate codes
    localparam logic [3:0] CODE_AUX_B    = 4'h3;
    localparam logic [3:0] CODE_AUX_A    = 4'h4;
    localparam logic [3:0] CODE_MAIN_48  = 4'h5;
    localparam logic [3:0] CODE_SEC_MIX  = 4'hB;
    // Divide ratios
    localparam logic [6:0] DIV_1  = 7'h01;
    localparam logic [6:0] DIV_2  = 7'h02;
    localparam logic [6:0] DIV_4  = 7'h04;
    localparam logic [6:0] DIV_6  = 7'h06;
    localparam logic [6:0] DIV_8  = 7'h08;
    localparam logic [6:0] DIV_12 = 7'h0C;
    localparam logic [6:0] DIV_16 = 7'h10;
    localparam logic [6:0] DIV_48 = 7'h30;
    localparam logic [6:0] DIV_64 = 7'h40;
    // Auxiliary rates in kHz, index {family, code}; 16384 needs all 15 bits
    localparam logic [14:0] AUX_KHZ_2048  = 15'h0800;
    localparam logic [14:0] AUX_KHZ_4096  = 15'h1000;
    localparam logic [14:0] AUX_KHZ_8192  = 15'h2000;
    localparam logic [14:0] AUX_KHZ_16384 = 15'h4000;
    localparam logic [14:0] AUX_KHZ_1544  = 15'h0608;
    localparam logic [14:0] AUX_KHZ_3088  = 15'h0C10;
    localparam logic [14:0] AUX_KHZ_6176  = 15'h1820;
    localparam logic [14:0] AUX_KHZ_12352 = 15'h3040;
endpackage

// file: rtl/output_clock_rate_selector.sv
// Output clock rate selector: register file and seven port decoders
`timescale 1ns/10ps
module output_clock_rate_selector
    import rate_sel_pkg::*;
(
    // Clock and reset
    input  wire logic        i_clock,
    input  wire logic        i_rst,
    // Register port
    input  wire logic [7:0]  i_reg_addr,
    input  wire logic [7:0]  i_reg_wdata,
    input  wire logic        i_reg_write,
    input  wire logic        i_reg_read,
    output logic [7:0]       o_reg_rdata,
    output logic             o_reg_rvalid,
    // Port selections, index 0 is port one
    output src_t             o_port_source [NUM_PORTS],
    output logic [6:0]       o_port_divide [NUM_PORTS],
    // Auxiliary rates in kHz
    output logic [14:0]      o_aux_a_khz,
    output logic [14:0]      o_aux_b_khz,
    // Composite output and secondary feedback clock choice
    output logic             o_composite_enable,
    output logic             o_sec_fb_from_apll
);
    logic [7:0]  rate_q [4];
    logic [7:0]  rate_d [4];
    logic [7:0]  eth_q;
    logic [7:0]  eth_d;
    logic [7:0]  fam_q;
    logic [7:0]  fam_d;
    logic [7:0]  auxc_q;
    logic [7:0]  auxc_d;
    logic [7:0]  misc_q;
    logic [7:0]  misc_d;
    logic [7:0]  rdata_d;
    logic [7:0]  rdata_q;
    logic        rvalid_q;
    logic [14:0] aux_a_d;
    logic [14:0] aux_b_d;
    logic [14:0] aux_a_q;
    logic [14:0] aux_b_q;
    logic [3:0]  port_code [NUM_PORTS];

    // Auxiliary rate lookup
    function automatic logic [14:0] aux_khz(input logic family, input logic [1:0] code);
        logic [14:0] khz;
        khz = AUX_KHZ_2048;
        unique case ({family, code})
            3'h0: khz = AUX_KHZ_2048;
            3'h1: khz = AUX_KHZ_4096;
            3'h2: khz = AUX_KHZ_8192;
            3'h3: khz = AUX_KHZ_16384;
            3'h4: khz = AUX_KHZ_1544;
            3'h5: khz = AUX_KHZ_3088;
            3'h6: khz = AUX_KHZ_6176;
            3'h7: khz = AUX_KHZ_12352;
        endcase
        return khz;
    endfunction

    // Register writes, whole byte at a time
    always_comb
    begin
        rate_d = rate_q;
        eth_d  = eth_q;
        fam_d  = fam_q;
        auxc_d = auxc_q;
        misc_d = misc_q;
        if (i_reg_write)
        begin
            unique case (i_reg_addr)
                RATE_P12_OFFSET:   rate_d[0] = i_reg_wdata;
                RATE_P34_OFFSET:   rate_d[1] = i_reg_wdata;
                RATE_P56_OFFSET:   rate_d[2] = i_reg_wdata;
                RATE_P7_OFFSET:    rate_d[3] = i_reg_wdata;
                ETH_SELECT_OFFSET: eth_d     = i_reg_wdata;
                AUX_FAMILY_OFFSET: fam_d     = i_reg_wdata;
                AUX_CODE_OFFSET:   auxc_d    = i_reg_wdata;
                MISC_CTRL_OFFSET:  misc_d    = i_reg_wdata;
                default:           rate_d    = rate_q;
            endcase
        end
    end

    // Read data and auxiliary rates
    always_comb
    begin
        unique case (i_reg_addr)
            RATE_P12_OFFSET:   rdata_d = rate_q[0];
            RATE_P34_OFFSET:   rdata_d = rate_q[1];
            RATE_P56_OFFSET:   rdata_d = rate_q[2];
            RATE_P7_OFFSET:    rdata_d = rate_q[3];
            ETH_SELECT_OFFSET: rdata_d = eth_q;
            AUX_FAMILY_OFFSET: rdata_d = fam_q;
            AUX_CODE_OFFSET:   rdata_d = auxc_q;
            MISC_CTRL_OFFSET:  rdata_d = misc_q;
            default:           rdata_d = 8'h00;
        endcase
        aux_a_d = aux_khz(fam_q[AUX_A_FAMILY_BIT], auxc_q[AUX_A_CODE_LSB +: 2]);
        aux_b_d = aux_khz(fam_q[AUX_B_FAMILY_BIT], auxc_q[AUX_B_CODE_LSB +: 2]);
    end

    // Register state
    always_ff @(posedge i_clock)
    begin
        if (i_rst)
        begin
            rate_q   <= '{default: REG_RESET};
            eth_q    <= REG_RESET;
            fam_q    <= REG_RESET;
            auxc_q   <= REG_RESET;
            misc_q   <= REG_RESET;
            rdata_q  <= 8'h00;
            rvalid_q <= 1'b0;
            aux_a_q  <= AUX_KHZ_2048;
            aux_b_q  <= AUX_KHZ_2048;
        end
        else
        begin
            rate_q   <= rate_d;
            eth_q    <= eth_d;
            fam_q    <= fam_d;
            auxc_q   <= auxc_d;
            misc_q   <= misc_d;
            rdata_q  <= i_reg_read ? rdata_d : 8'h00;
            rvalid_q <= i_reg_read;
            aux_a_q  <= aux_a_d;
            aux_b_q  <= aux_b_d;
        end
    end

    // Nibble of each port
    always_comb
    begin
        for (int p = 0; p < NUM_PORTS; p++)
            port_code[p] = (p % 2 == 0) ? rate_q[p / 2][3:0] : rate_q[p / 2][7:4];
    end

    // One decoder per port; ports three and seven cannot select an auxiliary source
    for (genvar g = 0; g < NUM_PORTS; g++)
    begin : g_port
        port_rate_decode #(
            .PORT_NUM (g + 1),
            .AUX_OK   ((g != 2) && (g != 6))
        ) u_dec (
            .i_clock   (i_clock),
            .i_rst     (i_rst),
            .i_code    (port_code[g]),
            .i_eth_sel ((g < ETH_PORTS) ? eth_q[g] : 1'b0),
            .o_source  (o_port_source[g]),
            .o_divide  (o_port_divide[g])
        );
    end

    assign o_reg_rdata        = rdata_q;
    assign o_reg_rvalid       = rvalid_q;
    assign o_aux_a_khz        = aux_a_q;
    assign o_aux_b_khz        = aux_b_q;
    assign o_composite_enable = misc_q[COMPOSITE_EN_BIT];
    assign o_sec_fb_from_apll = misc_q[SEC_FB_APLL_BIT];

    // Checks
    chk_port1_nibble: assert property (@(posedge i_clock) disable iff (i_rst)
        (i_reg_write && i_reg_addr == RATE_P12_OFFSET && i_reg_wdata[3:0] == 4'h6
         && !eth_q[0]) |=> ##1 (o_port_divide[0] == DIV_16))
        else $error("port one nibble not decoded");
    chk_code3_port6: assert property (@(posedge i_clock) disable iff (i_rst)
        ($past(port_code[5]) == CODE_AUX_B && !$past(eth_q[5]) && !$past(i_rst))
        |-> (o_port_source[5] == SRC_MAIN_APLL && o_port_divide[5] == DIV_2))
        else $error("port six code 3 wrong");
    chk_code4_port7: assert property (@(posedge i_clock) disable iff (i_rst)
        ($past(port_code[6]) == CODE_AUX_A && !$past(i_rst))
        |-> (o_port_source[6] == SRC_MAIN_APLL && o_port_divide[6] == DIV_2))
        else $error("port seven code 4 wrong");
    chk_main_div4: assert property (@(posedge i_clock) disable iff (i_rst)
        ($past(port_code[1]) == 4'hA && !$past(eth_q[1]) && !$past(i_rst))
        |-> (o_port_source[1] == SRC_MAIN_APLL && o_port_divide[1] == DIV_4))
        else $error("main divide by 4 wrong");
    chk_sec_mix: assert property (@(posedge i_clock) disable iff (i_rst)
        ($past(port_code[3]) == CODE_SEC_MIX && !$past(eth_q[3]) && !$past(i_rst))
        |-> (o_port_source[3] == SRC_SEC_APLL && o_port_divide[3] == DIV_2))
        else $error("port four code B wrong");
    chk_sec_div48: assert property (@(posedge i_clock) disable iff (i_rst)
        ($past(port_code[6]) == 4'hC && !$past(i_rst))
        |-> (o_port_source[6] == SRC_SEC_APLL && o_port_divide[6] == DIV_48))
        else $error("secondary divide by 48 wrong");
    chk_eth_port1: assert property (@(posedge i_clock) disable iff (i_rst)
        ($past(eth_q[0]) && $past(port_code[0][1:0]) == 2'b10 && !$past(i_rst))
        |-> o_port_source[0] == SRC_ETH_62M5)
        else $error("port one 62.5 MHz wrong");
    chk_eth_other: assert property (@(posedge i_clock) disable iff (i_rst)
        ($past(eth_q[2]) && $past(port_code[2][1:0]) == 2'b01 && !$past(i_rst))
        |-> o_port_source[2] == SRC_2K)
        else $error("port three Ethernet 2 kHz wrong");
    chk_aux_family: assert property (@(posedge i_clock) disable iff (i_rst)
        (fam_q[AUX_A_FAMILY_BIT] && auxc_q[AUX_A_CODE_LSB +: 2] == 2'b11) ##1
        $stable(fam_q) && $stable(auxc_q) |-> o_aux_a_khz == AUX_KHZ_12352)
        else $error("aux A rate wrong");
endmodule

// file: rtl/port_rate_decode.sv
// Per-port rate code decoder with registered source and divide ratio
`timescale 1ns/10ps
module port_rate_decode
    import rate_sel_pkg::*;
#(
    parameter int PORT_NUM = 1,
    parameter bit AUX_OK   = 1'b1
)
(
    // Clock and reset
    input  wire logic       i_clock,
    input  wire logic       i_rst,
    // Selection
    input  wire logic [3:0] i_code,
    input  wire logic       i_eth_sel,
    // Decoded selection
    output src_t            o_source,
    output logic [6:0]      o_divide
);
    src_t       source_d;
    src_t       source_q;
    logic [6:0] divide_d;
    logic [6:0] divide_q;

    // Decode the code for this port
    always_comb
    begin
        source_d = SRC_OFF;
        divide_d = DIV_1;
        if (i_eth_sel && PORT_NUM <= ETH_PORTS)
        begin
            unique case (i_code[1:0])
                2'b00: source_d = SRC_ETH_25M;
                2'b01: source_d = (PORT_NUM == 1) ? SRC_ETH_50M : SRC_2K;
                2'b10: source_d = (PORT_NUM == 1) ? SRC_ETH_62M5 : SRC_8K;
                2'b11: source_d = SRC_ETH_125M;
            endcase
        end
        else
        begin
            unique case (i_code)
                4'h0: source_d = SRC_OFF;
                4'h1: source_d = SRC_2K;
                4'h2: source_d = SRC_8K;
                CODE_AUX_B:
                begin
                    if (PORT_NUM == 6)
                    begin
                        source_d = SRC_MAIN_APLL;
                        divide_d = DIV_2;
                    end
                    else
                        source_d = AUX_OK ? SRC_AUX_B : SRC_OFF;
                end
                CODE_AUX_A:
                begin
                    if (PORT_NUM == 7)
                    begin
                        source_d = SRC_MAIN_APLL;
                        divide_d = DIV_2;
                    end
                    else
                        source_d = AUX_OK ? SRC_AUX_A : SRC_OFF;
                end
                CODE_MAIN_48:
                begin
                    source_d = SRC_MAIN_APLL;
                    divide_d = DIV_48;
                end
                4'h6, 4'h7, 4'h8, 4'h9, 4'hA:
                begin
                    source_d = SRC_MAIN_APLL;
                    unique case (i_code)
                        4'h6:    divide_d = DIV_16;
                        4'h7:    divide_d = DIV_12;
                        4'h8:    divide_d = DIV_8;
                        4'h9:    divide_d = DIV_6;
                        default: divide_d = DIV_4;
                    endcase
                end
                CODE_SEC_MIX:
                begin
                    source_d = SRC_SEC_APLL;
                    divide_d = (PORT_NUM == 4 || PORT_NUM == 5) ? DIV_2 : DIV_64;
                end
                4'hC, 4'hD, 4'hE, 4'hF:
                begin
                    source_d = SRC_SEC_APLL;
                    unique case (i_code[1:0])
                        2'b00: divide_d = DIV_48;
                        2'b01: divide_d = DIV_16;
                        2'b10: divide_d = DIV_8;
                        2'b11: divide_d = DIV_4;
                    endcase
                end
            endcase
        end
    end

    // Register the decoded selection, tracking every new code
    always_ff @(posedge i_clock)
    begin
        if (i_rst)
        begin
            source_q <= SRC_OFF;
            divide_q <= DIV_1;
        end
        else
        begin
            source_q <= source_d;
            divide_q <= divide_d;
        end
    end

    assign o_source = source_q;
    assign o_divide = divide_q;
endmodule

// file: verification/tb.sv
// Self-checking testbench for the output clock rate selector
`timescale 1ns/10ps
module tb
    import rate_sel_pkg::*;
;
    localparam logic [7:0] MAPPED [8] = '{ETH_SELECT_OFFSET, AUX_FAMILY_OFFSET, AUX_CODE_OFFSET,
        RATE_P12_OFFSET, RATE_P34_OFFSET, RATE_P56_OFFSET, RATE_P7_OFFSET, MISC_CTRL_OFFSET};
    // Design connections
    logic        i_clock;
    logic        i_rst;
    logic [7:0]  i_reg_addr;
    logic [7:0]  i_reg_wdata;
    logic        i_reg_write;
    logic        i_reg_read;
    logic [7:0]  o_reg_rdata;
    logic        o_reg_rvalid;
    src_t        o_port_source [NUM_PORTS];
    logic [6:0]  o_port_divide [NUM_PORTS];
    logic [14:0] o_aux_a_khz;
    logic [14:0] o_aux_b_khz;
    logic        o_composite_enable;
    logic        o_sec_fb_from_apll;
    // Bench state
    logic [7:0]  exp_q [$];
    logic [7:0]  shadow [256];
    logic [3:0]  codes [NUM_PORTS];
    logic [5:0]  eth;
    logic [31:0] seed;
    logic [31:0] r;
    int          error_cnt;
    int          checked;

    output_clock_rate_selector dut (
        .i_clock            (i_clock),
        .i_rst              (i_rst),
        .i_reg_addr         (i_reg_addr),
        .i_reg_wdata        (i_reg_wdata),
        .i_reg_write        (i_reg_write),
        .i_reg_read         (i_reg_read),
        .o_reg_rdata        (o_reg_rdata),
        .o_reg_rvalid       (o_reg_rvalid),
        .o_port_source      (o_port_source),
        .o_port_divide      (o_port_divide),
        .o_aux_a_khz        (o_aux_a_khz),
        .o_aux_b_khz        (o_aux_b_khz),
        .o_composite_enable (o_composite_enable),
        .o_sec_fb_from_apll (o_sec_fb_from_apll)
    );

    // Clock, 5 ns period
    always #2.5 i_clock = ~i_clock;

    // Pseudo-random source
    function automatic logic [31:0] xs();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction

    // Expected source and divide of one port, {source, divide}
    function automatic logic [10:0] exp_sel(input int idx, input logic [3:0] c, input logic e);
        src_t       s;
        logic [6:0] d;
        logic       aux;
        s = SRC_OFF;
        d = DIV_1;
        aux = (idx != 2) && (idx != 6);
        if (e)
        begin
            case (c[1:0])
                2'h0: s = SRC_ETH_25M;
                2'h1: s = (idx == 0) ? SRC_ETH_50M : SRC_2K;
                2'h2: s = (idx == 0) ? SRC_ETH_62M5 : SRC_8K;
                default: s = SRC_ETH_125M;
            endcase
        end
        else
        begin
            case (c)
                4'h0: s = SRC_OFF;
                4'h1: s = SRC_2K;
                4'h2: s = SRC_8K;
                4'h3: s = aux ? SRC_AUX_B : SRC_OFF;
                4'h4: s = aux ? SRC_AUX_A : SRC_OFF;
                default: s = (c < 4'hB) ? SRC_MAIN_APLL : SRC_SEC_APLL;
            endcase
            case (c)
                4'h5: d = DIV_48;
                4'h6: d = DIV_16;
                4'h7: d = DIV_12;
                4'h8: d = DIV_8;
                4'h9: d = DIV_6;
                4'hA: d = DIV_4;
                4'hB: d = (idx == 3 || idx == 4) ? DIV_2 : DIV_64;
                4'hC: d = DIV_48;
                4'hD: d = DIV_16;
                4'hE: d = DIV_8;
                4'hF: d = DIV_4;
                default: d = DIV_1;
            endcase
            if ((c == 4'h3 && idx == 5) || (c == 4'h4 && idx == 6))
            begin
                s = SRC_MAIN_APLL;
                d = DIV_2;
            end
        end
        return {s, d};
    endfunction

    // Expected auxiliary rate in kHz
    function automatic logic [14:0] aux_khz(input logic f, input logic [1:0] c);
        case ({f, c})
            3'h0: return AUX_KHZ_2048;
            3'h1: return AUX_KHZ_4096;
            3'h2: return AUX_KHZ_8192;
            3'h3: return AUX_KHZ_16384;
            3'h4: return AUX_KHZ_1544;
            3'h5: return AUX_KHZ_3088;
            3'h6: return AUX_KHZ_6176;
            default: return AUX_KHZ_12352;
        endcase
    endfunction

    task automatic chk(input string nm, input logic [15:0] exp, input logic [15:0] got);
        checked++;
        if (got !== exp)
        begin
            error_cnt++;
            $display("[ERR] %s expected %h seen %h", nm, exp, got);
        end
    endtask

    // Register port cycles; strobes stay high across back-to-back calls
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge i_clock);
        i_reg_write <= 1'b1;
        i_reg_read  <= 1'b0;
        i_reg_addr  <= a;
        i_reg_wdata <= d;
        if (a inside {MAPPED})
            shadow[a] = d;
    endtask

    task automatic rd(input logic [7:0] a, input logic wr_too);
        @(posedge i_clock);
        i_reg_read  <= 1'b1;
        i_reg_write <= wr_too;
        i_reg_addr  <= a;
        exp_q.push_back(shadow[a]);
        if (wr_too && (a inside {MAPPED}))
            shadow[a] = i_reg_wdata;
    endtask

    task automatic read_all();
        foreach (MAPPED[i])
            rd(MAPPED[i], 1'b0);
        rd(8'h55, 1'b0);
    endtask

    // Release strobes and let the decoder registers follow
    task automatic settle();
        @(posedge i_clock);
        i_reg_write <= 1'b0;
        i_reg_read  <= 1'b0;
        repeat (3) @(posedge i_clock);
        #1;
    endtask

    task automatic do_reset();
        @(posedge i_clock);
        i_rst       <= 1'b1;
        i_reg_write <= 1'b0;
        i_reg_read  <= 1'b0;
        repeat (3) @(posedge i_clock);
        i_rst <= 1'b0;
        foreach (shadow[i])
            shadow[i] = REG_RESET;
        foreach (codes[i])
            codes[i] = 4'h0;
        eth = 6'h00;
        #1;
    endtask

    task automatic write_ports();
        r = xs();
        wr(ETH_SELECT_OFFSET, {r[7:6], eth});
        wr(RATE_P12_OFFSET, {codes[1], codes[0]});
        wr(RATE_P34_OFFSET, {codes[3], codes[2]});
        wr(RATE_P56_OFFSET, {codes[5], codes[4]});
        wr(RATE_P7_OFFSET, {r[11:8], codes[6]});
        settle();
    endtask

    task automatic check_ports();
        logic [10:0] e;
        for (int i = 0; i < NUM_PORTS; i++)
        begin
            e = exp_sel(i, codes[i], (i < ETH_PORTS) ? eth[i] : 1'b0);
            chk("port_source", 16'(e[10:7]), 16'(o_port_source[i]));
            chk("port_divide", 16'(e[6:0]), 16'(o_port_divide[i]));
        end
    endtask

    task automatic close_out();
        if (exp_q.size() != 0)
            error_cnt++;
        $display("checked %0d error_cnt %0d", checked, error_cnt);
        if (error_cnt == 0 && checked > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask

    // Read monitor: oldest note against each returned byte
    always @(posedge i_clock)
    begin
        if (!i_rst && o_reg_rvalid === 1'b1)
        begin
            if (exp_q.size() == 0)
                chk("rvalid_spurious", 16'h0000, 16'h0001);
            else
                chk("reg_rdata", {8'h00, exp_q.pop_front()}, {8'h00, o_reg_rdata});
        end
        else if (!i_rst && checked > 0)
            chk("idle_rdata", 16'h0000, {8'h00, o_reg_rdata});
    end

    // Watchdog
    initial
    begin
        repeat (20000) @(posedge i_clock);
        $display("[ERR] watchdog expected finish seen timeout");
        error_cnt++;
        close_out();
    end

    // Main sequence
    initial
    begin
        i_clock = 1'b0;
        i_rst = 1'b1;
        i_reg_addr = 8'h00;
        i_reg_wdata = 8'h00;
        i_reg_write = 1'b0;
        i_reg_read = 1'b0;
        seed = 32'h00013580;
        error_cnt = 0;
        checked = 0;
        do_reset();
        check_ports();
        chk("aux_a_khz", 16'(AUX_KHZ_2048), 16'(o_aux_a_khz));
        chk("composite_enable", 16'h0000, 16'(o_composite_enable));
        read_all();
        // Every code on every port, plain then Ethernet meaning
        for (int m = 0; m < 2; m++)
            for (int c = 0; c < 16; c++)
            begin
                eth = (m == 1) ? 6'h3F : 6'h00;
                foreach (codes[i])
                    codes[i] = 4'(c);
                write_ports();
                check_ports();
            end
        // Random per-port fields, read back after each
        repeat (24)
        begin
            r = xs();
            eth = r[29:24];
            foreach (codes[i])
                codes[i] = r[4*i +: 4];
            write_ports();
            check_ports();
            read_all();
        end
        // Ethernet selection dropped and restored by software, ports re-checked
        eth = 6'h00;
        write_ports();
        eth = 6'h3F;
        write_ports();
        check_ports();
        // Auxiliary rates, both families and codes
        for (int f = 0; f < 2; f++)
            for (int c = 0; c < 4; c++)
            begin
                wr(AUX_FAMILY_OFFSET, {1'b0, ~f[0], f[0], 5'h00});
                wr(AUX_CODE_OFFSET, {2'(3 - c), 2'(c), 4'h0});
                settle();
                chk("aux_a_khz", 16'(aux_khz(f[0], 2'(c))), 16'(o_aux_a_khz));
                chk("aux_b_khz", 16'(aux_khz(~f[0], 2'(3 - c))), 16'(o_aux_b_khz));
            end
        // Composite enable and secondary feedback choice
        wr(MISC_CTRL_OFFSET, 8'h01);
        settle();
        chk("composite_enable", 16'h0001, 16'(o_composite_enable));
        chk("sec_fb_from_apll", 16'h0000, 16'(o_sec_fb_from_apll));
        wr(MISC_CTRL_OFFSET, 8'h02);
        settle();
        chk("composite_enable", 16'h0000, 16'(o_composite_enable));
        chk("sec_fb_from_apll", 16'h0001, 16'(o_sec_fb_from_apll));
        // Write and read together, unmapped write ignored
        wr(RATE_P12_OFFSET, 8'h5A);
        wr(8'h55, 8'hA5);
        rd(RATE_P12_OFFSET, 1'b1);
        read_all();
        settle();
        // Reset in mid-run clears everything
        do_reset();
        check_ports();
        read_all();
        settle();
        close_out();
    end
endmodule
